// ===== dcs_control_status.sv
`timescale 1ns/10ps
`default_nettype none

module dcs_control_status
  import dcs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        csr_wr,
  input  wire logic [15:0] csr_wdata,
  input  wire logic        disk_addr_bit3,
  input  wire logic        cmd_done,
  input  wire logic [3:0]  cmd_err_code,
  input  wire logic        irq_ack,
  input  wire logic        drive_ready_pin,
  input  wire logic        drive_error_pin,
  output logic      [15:0] csr_rdata,
  output logic             cmd_start,
  output logic      [2:0]  command_code_field,
  output logic      [1:0]  drive_sel,
  output logic             mem_addr_bit_sixteen,
  output logic             mem_addr_bit_seventeen,
  output logic             drive_err_clear,
  output logic             irq_req
);

  typedef struct packed {
    logic [2:0]  cmd;
    logic [1:0]  addr_hi;
    logic        irq_enable;
    logic        ready;
    logic [1:0]  dsel;
    logic [3:0]  err;
    logic        start;
    logic        drv_err_clr;
    logic        irq;
    logic [15:0] rdata;
  } dcs_state_type;

  dcs_state_type st_reg;
  dcs_state_type st_next;
  logic          drv_ready_s;
  logic          drv_err_s;
  logic          go_req;

  // Drive status lines come from another chassis and are synchronised first.
  dcs_sync2 #(
    .WIDTH (2)
  ) u_dcs_sync2 (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({drive_error_pin, drive_ready_pin}),
    .sync_out ({drv_err_s, drv_ready_s})
  );

  // A go request only counts while the controller is idle; writing zero to a busy
  // controller cannot restart the running command.
  assign go_req = csr_wr && !csr_wdata[DCS_BIT_CTRL_RDY] && st_reg.ready;

  // Next state of the whole register and its side effects.
  always_comb
  begin
    st_next             = st_reg;
    st_next.start       = 1'b0;
    st_next.drv_err_clr = 1'b0;
    if (csr_wr)
    begin
      st_next.cmd        = csr_wdata[DCS_BIT_CMD_HI:DCS_BIT_CMD_LO];
      st_next.addr_hi    = csr_wdata[DCS_BIT_ADDR_HI:DCS_BIT_ADDR_LO];
      st_next.irq_enable = csr_wdata[DCS_BIT_IRQ_EN];
      st_next.dsel       = csr_wdata[DCS_BIT_DSEL_HI:DCS_BIT_DSEL_LO];
    end
    if (go_req)
    begin
      st_next.ready       = 1'b0;
      st_next.err         = DCS_ERR_NONE;
      st_next.start       = 1'b1;
      st_next.drv_err_clr = (csr_wdata[DCS_BIT_CMD_HI:DCS_BIT_CMD_LO] == DCS_CMD_GET_STATUS)
                            && disk_addr_bit3;
    end
    // Completion only arrives while busy, so it never meets a go request.
    if (cmd_done && !st_reg.ready)
    begin
      st_next.ready = 1'b1;
      st_next.err   = cmd_err_code;
    end
    // The rising edge of ready raises the request; a new edge beats an acknowledge.
    if (irq_ack)
    begin
      st_next.irq = 1'b0;
    end
    if (st_next.ready && !st_reg.ready && st_next.irq_enable)
    begin
      st_next.irq = 1'b1;
    end
    // Read data is built from the next values so software never sees a stale word.
    st_next.rdata = {(|st_next.err) | drv_err_s,
                     drv_err_s,
                     st_next.err,
                     st_next.dsel,
                     st_next.ready,
                     st_next.irq_enable,
                     st_next.addr_hi,
                     st_next.cmd,
                     drv_ready_s};
  end

  // Initialization sets ready and clears every writable and error field.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_reg.cmd         <= DCS_RST_CMD;
      st_reg.addr_hi     <= DCS_RST_ADDR;
      st_reg.irq_enable  <= DCS_RST_IRQ_EN;
      st_reg.ready       <= DCS_RST_READY;
      st_reg.dsel        <= DCS_RST_DSEL;
      st_reg.err         <= DCS_RST_ERR;
      st_reg.start       <= 1'b0;
      st_reg.drv_err_clr <= 1'b0;
      st_reg.irq         <= 1'b0;
      st_reg.rdata       <= DCS_RST_WORD;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Every output is a flip-flop of the state.
  assign csr_rdata              = st_reg.rdata;
  assign cmd_start              = st_reg.start;
  assign command_code_field     = st_reg.cmd;
  assign drive_sel              = st_reg.dsel;
  assign mem_addr_bit_sixteen   = st_reg.addr_hi[0];
  assign mem_addr_bit_seventeen = st_reg.addr_hi[1];
  assign drive_err_clear        = st_reg.drv_err_clr;
  assign irq_req                = st_reg.irq;

  // A go is a write of zero to bit 7 while ready; it must start exactly one command.
  sequence s_go;
    csr_wr && !csr_wdata[DCS_BIT_CTRL_RDY] && csr_rdata[DCS_BIT_CTRL_RDY];
  endsequence

  // A completion pulse only counts while busy, because a stray one must not move ready.
  sequence s_finish;
    cmd_done && !csr_rdata[DCS_BIT_CTRL_RDY];
  endsequence

  // The pin bits are masked here since their synchronisers fill only after release.
  property p_reset_value;
    @(posedge clk_sys) $fell(rst) |-> (csr_rdata[13:1] == 13'h0040);
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("bad value after init");

  // Writable fields land one edge after the strobe.
  property p_cmd_store;
    @(posedge clk_sys) disable iff (rst)
      csr_wr |=> (command_code_field == $past(csr_wdata[3:1]));
  endproperty
  a_cmd_store: assert property (p_cmd_store)
    else $error("command code not stored");

  property p_addr_bits;
    @(posedge clk_sys) disable iff (rst)
      csr_wr |=> ({mem_addr_bit_seventeen, mem_addr_bit_sixteen} == $past(csr_wdata[5:4]));
  endproperty
  a_addr_bits: assert property (p_addr_bits)
    else $error("address bits not stored");

  // The start pulse lasts one cycle and ready drops with it.
  property p_go_starts;
    @(posedge clk_sys) disable iff (rst)
      s_go |=> (cmd_start && !csr_rdata[DCS_BIT_CTRL_RDY]) ##1 !cmd_start;
  endproperty
  a_go_starts: assert property (p_go_starts)
    else $error("go write did not start once");

  // Ready returns with the code sampled on the completion pulse.
  property p_finish_ready;
    @(posedge clk_sys) disable iff (rst)
      s_finish |=> csr_rdata[DCS_BIT_CTRL_RDY]
                   && (csr_rdata[13:10] == $past(cmd_err_code));
  endproperty
  a_finish_ready: assert property (p_finish_ready)
    else $error("end not reported");

  // An interrupt only ever rises together with ready and with the enable set.
  property p_irq_needs_enable;
    @(posedge clk_sys) disable iff (rst)
      $rose(irq_req) |-> csr_rdata[DCS_BIT_IRQ_EN] && csr_rdata[DCS_BIT_CTRL_RDY];
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable)
    else $error("interrupt without enable");

  property p_irq_on_end;
    @(posedge clk_sys) disable iff (rst)
      s_finish ##0 csr_rdata[DCS_BIT_IRQ_EN] ##0 !csr_wr |=> irq_req;
  endproperty
  a_irq_on_end: assert property (p_irq_on_end)
    else $error("no interrupt at command end");

  // An acknowledge clears the request unless a completion lands in the same cycle.
  property p_irq_ack;
    @(posedge clk_sys) disable iff (rst)
      irq_ack && !(cmd_done && !csr_rdata[DCS_BIT_CTRL_RDY]) |=> !irq_req;
  endproperty
  a_irq_ack: assert property (p_irq_ack)
    else $error("interrupt held after acknowledge");

  property p_composite;
    @(posedge clk_sys) disable iff (rst)
      csr_rdata[DCS_BIT_ANY_ERR] == (|csr_rdata[14:10]);
  endproperty
  a_composite: assert property (p_composite)
    else $error("composite error mismatch");

  // Three cycles cover the two synchroniser stages and the read word register.
  property p_drive_err;
    @(posedge clk_sys) disable iff (rst)
      $rose(drive_error_pin) ##1 drive_error_pin [*3] |-> csr_rdata[DCS_BIT_DRV_ERR];
  endproperty
  a_drive_err: assert property (p_drive_err)
    else $error("drive error not shown");

  property p_de_clear;
    @(posedge clk_sys) disable iff (rst)
      s_go ##0 (csr_wdata[3:1] == 3'h2) ##0 disk_addr_bit3 |=> drive_err_clear;
  endproperty
  a_de_clear: assert property (p_de_clear)
    else $error("drive error clear missing");

endmodule

`default_nettype wire

// ===== dcs_pkg.sv
`default_nettype none

package dcs_pkg;

  // Field positions inside the 16-bit control and status word.
  localparam int unsigned DCS_BIT_DRV_READY = 0;
  localparam int unsigned DCS_BIT_CMD_LO    = 1;
  localparam int unsigned DCS_BIT_CMD_HI    = 3;
  localparam int unsigned DCS_BIT_ADDR_LO   = 4;
  localparam int unsigned DCS_BIT_ADDR_HI   = 5;
  localparam int unsigned DCS_BIT_IRQ_EN    = 6;
  localparam int unsigned DCS_BIT_CTRL_RDY  = 7;
  localparam int unsigned DCS_BIT_DSEL_LO   = 8;
  localparam int unsigned DCS_BIT_DSEL_HI   = 9;
  localparam int unsigned DCS_BIT_ERR_LO    = 10;
  localparam int unsigned DCS_BIT_ERR_HI    = 13;
  localparam int unsigned DCS_BIT_DRV_ERR   = 14;
  localparam int unsigned DCS_BIT_ANY_ERR   = 15;

  // Values after controller initialization.
  localparam logic [2:0]  DCS_RST_CMD    = 3'h0;
  localparam logic [1:0]  DCS_RST_ADDR   = 2'h0;
  localparam logic        DCS_RST_IRQ_EN = 1'b0;
  localparam logic        DCS_RST_READY  = 1'b1;
  localparam logic [1:0]  DCS_RST_DSEL   = 2'h0;
  localparam logic [3:0]  DCS_RST_ERR    = 4'h0;
  // Whole word after initialization; the pin bits stay low until their synchronisers fill.
  localparam logic [15:0] DCS_RST_WORD   = 16'h0080;

  // Drive command codes.
  typedef enum logic [2:0] {
    DCS_CMD_NOP_MAINT    = 3'h0,
    DCS_CMD_WRITE_CHECK  = 3'h1,
    DCS_CMD_GET_STATUS   = 3'h2,
    DCS_CMD_SEEK         = 3'h3,
    DCS_CMD_READ_HEADER  = 3'h4,
    DCS_CMD_WRITE_DATA   = 3'h5,
    DCS_CMD_READ_DATA    = 3'h6,
    DCS_CMD_READ_NO_HDR  = 3'h7
  } dcs_cmd_type;

  // Error codes reported in the error code field.
  localparam logic [3:0] DCS_ERR_NONE                 = 4'h0;
  localparam logic [3:0] DCS_ERR_OP_INCOMPLETE_ERR    = 4'h1;
  localparam logic [3:0] DCS_ERR_DATA_CRC_ERR         = 4'h2;
  localparam logic [3:0] DCS_ERR_HEADER_CRC_ERR       = 4'h3;
  localparam logic [3:0] DCS_ERR_DATA_LATE_ERR        = 4'h4;
  localparam logic [3:0] DCS_ERR_HEADER_MISSING_ERR   = 4'h5;
  localparam logic [3:0] DCS_ERR_NO_MEMORY_ERR        = 4'h8;
  localparam logic [3:0] DCS_ERR_MEM_PARITY_ERR       = 4'h9;

  // Bit of the disk address register that asks a get-status to clear a drive error.
  localparam int unsigned DCS_DISK_ADDR_BIT_RESET_DRIVE = 3;

endpackage

`default_nettype wire

// ===== dcs_sync2.sv
`timescale 1ns/10ps
`default_nettype none

module dcs_sync2
  import dcs_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } dcs_sync_type;

  dcs_sync_type st_reg;
  dcs_sync_type st_next;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_comb
  begin
    st_next.stage1 = async_in;
    st_next.stage2 = st_reg.stage1;
  end

  // Both stages clear under reset and shift on every edge.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stage2;

endmodule

`default_nettype wire

// ===== dcs_far_model.sv
`timescale 1ns/10ps
`default_nettype none

module dcs_far_model
  import dcs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       cmd_start,
  input  wire logic       drive_err_clear,
  input  wire logic       fault_set,
  input  wire logic [3:0] err_to_report,
  output logic            cmd_done,
  output logic      [3:0] cmd_err_code,
  output logic            drive_ready_pin,
  output logic            drive_error_pin
);
  logic       busy_reg;
  logic [3:0] count_reg;

  // Sequencer and drive in one. The error code only means something with the done
  // pulse, so it toggles elsewhere to catch a controller that samples it late.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      busy_reg        <= 1'b0;
      count_reg       <= 4'h0;
      cmd_done        <= 1'b0;
      cmd_err_code    <= 4'hA;
      drive_ready_pin <= 1'b1;
      drive_error_pin <= 1'b0;
    end
    else
    begin
      cmd_done     <= 1'b0;
      cmd_err_code <= ~cmd_err_code;
      if (cmd_start)
      begin
        busy_reg  <= 1'b1;
        count_reg <= 4'hA;
      end
      else if (busy_reg && count_reg == 4'h0)
      begin
        busy_reg     <= 1'b0;
        cmd_done     <= 1'b1;
        cmd_err_code <= err_to_report;
      end
      else if (busy_reg)
        count_reg <= count_reg - 4'h1;
      drive_ready_pin <= !busy_reg;
      if (fault_set)
        drive_error_pin <= 1'b1;
      else if (drive_err_clear)
        drive_error_pin <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== tb_dcs_control_status.sv
`timescale 1ns/10ps
`default_nettype none

module tb_dcs_control_status
  import dcs_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        csr_wr = 1'b0;
  logic [15:0] csr_wdata = 16'h0000;
  logic        disk_addr_bit3 = 1'b0;
  logic        irq_ack = 1'b0;
  logic        fault_set = 1'b0;
  logic [3:0]  err_to_report = 4'h0;
  logic        cmd_done;
  logic [3:0]  cmd_err_code;
  logic        drive_ready_pin;
  logic        drive_error_pin;
  logic [15:0] csr_rdata;
  logic        cmd_start;
  logic [2:0]  command_code_field;
  logic [1:0]  drive_sel;
  logic        mem_addr_bit_sixteen;
  logic        mem_addr_bit_seventeen;
  logic        drive_err_clear;
  logic        irq_req;
  int          bad_count = 0;
  int          checks = 0;
  logic [2:0]  c;
  logic        irq_en;
  logic [15:0] word;
  logic [3:0]  errs [8] = '{DCS_ERR_NONE, DCS_ERR_OP_INCOMPLETE_ERR, DCS_ERR_DATA_CRC_ERR,
    DCS_ERR_HEADER_CRC_ERR, DCS_ERR_DATA_LATE_ERR, DCS_ERR_HEADER_MISSING_ERR,
    DCS_ERR_NO_MEMORY_ERR, DCS_ERR_MEM_PARITY_ERR};

  // Free-running system clock, 4 ns period.
  always #2 clk_sys = ~clk_sys;

  dcs_control_status u_dcs_control_status (.clk_sys(clk_sys), .rst(rst), .csr_wr(csr_wr),
    .csr_wdata(csr_wdata), .disk_addr_bit3(disk_addr_bit3), .cmd_done(cmd_done),
    .cmd_err_code(cmd_err_code), .irq_ack(irq_ack), .drive_ready_pin(drive_ready_pin),
    .drive_error_pin(drive_error_pin), .csr_rdata(csr_rdata), .cmd_start(cmd_start),
    .command_code_field(command_code_field), .drive_sel(drive_sel),
    .mem_addr_bit_sixteen(mem_addr_bit_sixteen),
    .mem_addr_bit_seventeen(mem_addr_bit_seventeen), .drive_err_clear(drive_err_clear),
    .irq_req(irq_req));

  dcs_far_model u_dcs_far_model (.clk_sys(clk_sys), .rst(rst), .cmd_start(cmd_start),
    .drive_err_clear(drive_err_clear), .fault_set(fault_set), .err_to_report(err_to_report),
    .cmd_done(cmd_done), .cmd_err_code(cmd_err_code), .drive_ready_pin(drive_ready_pin),
    .drive_error_pin(drive_error_pin));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe; returns just after the taking edge so the new word is visible.
  task automatic write_csr(input logic [15:0] data, input logic addr_bit3, input logic [3:0] err);
    @(posedge clk_sys);
    csr_wr         <= 1'b1;
    csr_wdata      <= data;
    disk_addr_bit3 <= addr_bit3;
    err_to_report  <= err;
    @(posedge clk_sys);
    csr_wr <= 1'b0;
    #1;
  endtask

  // Bounded wait for the ready bit, so a stuck controller cannot hang the run.
  task automatic wait_ready;
    int n;
    n = 0;
    while (csr_rdata[7] !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check({15'h0, n < 100}, 16'h0001);
  endtask

  task automatic end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog sized well above the roughly 160 cycles the sequence needs.
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    end_of_test();
  end

  // Main sequence: field write without go, then every command, each with its own error code.
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    check(csr_rdata, 16'h0081);
    write_csr(16'hFFFE, 1'b0, 4'h0);
    check(csr_rdata, 16'h03FF);
    check({cmd_start, drive_sel, mem_addr_bit_seventeen, mem_addr_bit_sixteen,
      command_code_field}, 16'h007F);
    for (int i = 0; i < 8; i++)
    begin
      c      = i[2:0];
      irq_en = (i != 0);
      word   = {6'h00, c[1:0], 1'b0, irq_en, c[2:1], c, 1'b0};
      if (i == 2)
      begin
        @(posedge clk_sys);
        fault_set <= 1'b1;
        @(posedge clk_sys);
        fault_set <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        check(csr_rdata & 16'hC000, 16'hC000);
      end
      write_csr(word, c[1], errs[i]);
      check({cmd_start, drive_err_clear}, {14'h0, 1'b1, i == 2});
      check(csr_rdata & 16'hFFFE, word | {{2{i == 2}}, 14'h0});
      if (i == 4)
      begin
        write_csr(word, c[1], errs[i]);
        check({15'h0, cmd_start}, 16'h0000);
      end
      wait_ready();
      check(csr_rdata & 16'hFFFE, {errs[i] != 4'h0, 1'b0, errs[i], c[1:0], 1'b1, irq_en,
        c[2:1], c, 1'b0});
      check({15'h0, irq_req}, {15'h0, irq_en});
      @(posedge clk_sys);
      irq_ack <= 1'b1;
      @(posedge clk_sys);
      irq_ack <= 1'b0;
      #1;
      check({15'h0, irq_req}, 16'h0000);
    end
    end_of_test();
  end
endmodule

`default_nettype wire
